/* File: bfc_pkg.sv */
package bfc_pkg;
   // time base
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned MS_NS = 1_000_000;
   localparam int unsigned MS_CYC = MS_NS / CLK_PERIOD_NS;
   localparam int unsigned MEAS_SPACING_NS = 57_000;
   localparam int unsigned MEAS_CYC = MEAS_SPACING_NS / CLK_PERIOD_NS;
   localparam int unsigned MIN_MS = 60_000;
   localparam int unsigned SEC_MS = 1_000;
   // per-mode times in their own units
   localparam int unsigned SAFETY_MIN_LOW = 80;
   localparam int unsigned SAFETY_MIN_MID = 160;
   localparam int unsigned SAFETY_MIN_HIGH = 40;
   localparam int unsigned HOLDOFF_S_LOW = 150;
   localparam int unsigned HOLDOFF_S_MID = 300;
   localparam int unsigned HOLDOFF_S_HIGH = 75;
   localparam logic [23:0] SAFETY_LOW = 24'(SAFETY_MIN_LOW * MIN_MS);
   localparam logic [23:0] SAFETY_MID = 24'(SAFETY_MIN_MID * MIN_MS);
   localparam logic [23:0] SAFETY_HIGH = 24'(SAFETY_MIN_HIGH * MIN_MS);
   localparam logic [23:0] HOLDOFF_LOW = 24'(HOLDOFF_S_LOW * SEC_MS);
   localparam logic [23:0] HOLDOFF_MID = 24'(HOLDOFF_S_MID * SEC_MS);
   localparam logic [23:0] HOLDOFF_HIGH = 24'(HOLDOFF_S_HIGH * SEC_MS);
   localparam logic [23:0] TRICKLE_MS_LOW = 24'd37;
   localparam logic [23:0] TRICKLE_MS_MID = 24'd73;
   localparam logic [23:0] TRICKLE_MS_HIGH = 24'd18;
   localparam logic [23:0] SYNC_MS_LOW = 24'd18700;
   localparam logic [23:0] SYNC_MS_MID = 24'd18700;
   localparam logic [23:0] SYNC_MS_HIGH = 24'd9400;
   localparam logic [23:0] FREE_RUN_MS = 24'd17000;
   localparam logic [23:0] HALF_FLASH_MS = 24'd500;
   localparam logic [9:0] SEC_LAST = 10'd999;
   localparam logic [3:0] HIST_RESET_MS = 4'd12;
   // averaging: counts minus one; drop thresholds in 0.5 mV steps
   localparam logic [5:0] AVG_LAST_PEAK = 6'd31;
   localparam logic [5:0] AVG_LAST_NDV = 6'd15;
   localparam logic [11:0] DROP_LSB_PEAK = 12'd5;
   localparam logic [11:0] DROP_LSB_NDV = 12'd24;
   // register map (byte addresses)
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_SAMPLE = 4'h8;
   localparam int unsigned CTRL_RESTART_BIT = 0;
   localparam logic [3:0] CAUSE_DROP = 4'h1;
   localparam logic [3:0] CAUSE_CEIL = 4'h2;
   localparam logic [3:0] CAUSE_TEMP = 4'h4;
   localparam logic [3:0] CAUSE_TIME = 4'h8;

   typedef enum logic [1:0] {
      MODE_LOW = 2'b00,
      MODE_MID = 2'b01,
      MODE_HIGH = 2'b10
   } bfc_mode_t;

   typedef enum logic [1:0] {
      ST_START = 2'b00,
      ST_PEND = 2'b01,
      ST_FAST = 2'b10,
      ST_DONE = 2'b11
   } bfc_state_t;

   // comparator results from the analog front end
   typedef struct packed {
      logic ceil;      // cell at or above the voltage ceiling
      logic floor_ok;  // cell above the voltage floor
      logic hot_ok;    // thermistor above the hot-fault limit
      logic cutoff;    // thermistor at or below the temperature cutoff
      logic det_range; // cell between 1 V and 2 V
   } bfc_sense_t;
endpackage

/* File: bfc_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - new cycle at power-up or ceiling fall
// - start: fast if in limits, else pending
// - pending: trickle, flash, leave on limits
// - at ceiling go complete, lamp off, trickle
// - fast ends on first termination condition
// - timing within twelve percent
// - high mode: terminate on 12 mV drop
// - low/mid mode: terminate on 2.5 mV drop
// - drop tests only between 1 and 2 V
// - sample on falling edge of sync pulse
// - no sync: free-run one sample per 17 s; low/mid mode never leaves sync by timeout
// - average 32 or 16 measurements 57 us apart
// - hold input over 12 ms erases history
// - hold input suspends fast, resumes exactly
// - gate released charges, low blocks, pulsed trickles
// - three-level mode selects all options
// - hold-off disables only drop tests
// - lamp low fast, flashes pending, else off
// - trickle pulse once per second
// - safety timer on fast, none on trickle
module bfc_sequencer #(
   parameter int unsigned P_MS_CYC = bfc_pkg::MS_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire bfc_pkg::bfc_sense_t i_sense,
   input wire logic [11:0] i_cell_meas,
   input wire logic [1:0] i_timer_mode_select,
   input wire logic i_charge_hold_in,
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic o_current_gate_out,
   output logic o_current_gate_out_oe,
   output logic o_status_lamp_out,
   output logic o_status_lamp_out_oe
);
   import bfc_pkg::*;
   function automatic logic [23:0] mode_pick(input bfc_mode_t m, input logic [23:0] lo,
                                             input logic [23:0] mid, input logic [23:0] hi);
      case (m)
         MODE_HIGH: mode_pick = hi;
         MODE_MID: mode_pick = mid;
         default: mode_pick = lo;
      endcase
   endfunction
   // bus slave: one wait cycle, then acknowledge
   logic wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   logic restart_req;
   // core state
   bfc_state_t st_q, st_d;
   bfc_mode_t mode_q, mode_d;
   logic [3:0] cause_q, cause_d;
   logic [15:0] ms_div_q, ms_div_d;
   logic [9:0] sec_ms_q, sec_ms_d;
   logic [23:0] fast_ms_q, fast_ms_d;
   logic [3:0] hold_ms_q, hold_ms_d;
   logic hold_prev_q, ceil_prev_q;
   logic [23:0] since_q, since_d;
   logic synced_q, synced_d;
   logic busy_q, busy_d;
   logic [10:0] mdiv_q, mdiv_d;
   logic [5:0] mcnt_q, mcnt_d;
   logic [16:0] acc_q, acc_d;
   logic [11:0] peak_q, peak_d, last_q, last_d;
   logic hist_q, hist_d, drop_q, drop_d;
   logic gate_oe_q, gate_oe_d, lamp_oe_q, lamp_oe_d;
   logic ms_tick, cyc_start, fast_ok, holdoff_ok, timer_end, hist_erase, trig;
   logic [16:0] sum;
   logic [11:0] avg;
   logic [23:0] sec24;
   always_comb begin
      wait_d = !((i_avs_read || i_avs_write) && wait_q);
      rdata_d = rdata_q;
      if (i_avs_read && wait_q) begin
         case (i_avs_address)
            REG_STATUS: rdata_d = {21'h0, hist_q, synced_q, i_charge_hold_in, cause_q,
                                   2'(mode_q), 2'(st_q)};
            REG_SAMPLE: rdata_d = {4'h0, peak_q, 4'h0, last_q};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end
   assign restart_req = i_avs_write && !wait_q && (i_avs_address == REG_CTRL)
                        && i_avs_writedata[CTRL_RESTART_BIT];
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         wait_q <= wait_d;
         rdata_q <= rdata_d;
      end
   end
   // single millisecond time base for every timer but the 57 us measurement spacing
   assign ms_tick = (32'(ms_div_q) == P_MS_CYC - 1);
   assign sec24 = 24'(sec_ms_q);
   assign cyc_start = (ceil_prev_q && !i_sense.ceil) || restart_req;
   assign fast_ok = i_sense.floor_ok && !i_sense.ceil && i_sense.hot_ok;
   assign holdoff_ok = fast_ms_q >= mode_pick(mode_q, HOLDOFF_LOW, HOLDOFF_MID,
                                              HOLDOFF_HIGH);
   assign timer_end = fast_ms_q >= mode_pick(mode_q, SAFETY_LOW, SAFETY_MID,
                                             SAFETY_HIGH);
   assign hist_erase = hold_ms_q > HIST_RESET_MS;
   assign sum = acc_q + 17'(i_cell_meas);
   assign avg = (mode_q == MODE_HIGH) ? sum[15:4] : sum[16:5];
   always_comb begin
      st_d = st_q;
      mode_d = mode_q;
      cause_d = cause_q;
      ms_div_d = ms_tick ? 16'h0000 : ms_div_q + 16'h0001;
      sec_ms_d = sec_ms_q;
      if (ms_tick) begin
         sec_ms_d = (sec_ms_q == SEC_LAST) ? 10'h000 : sec_ms_q + 10'h001;
      end
      fast_ms_d = fast_ms_q;
      case (st_q)
         ST_START: begin
            mode_d = i_timer_mode_select[1] ? MODE_HIGH :
                     (i_timer_mode_select[0] ? MODE_MID : MODE_LOW);
            fast_ms_d = 24'h00_0000;
            cause_d = 4'h0;
            st_d = fast_ok ? ST_FAST : ST_PEND;
         end
         ST_PEND: begin
            if (fast_ok) begin
               st_d = ST_FAST;
            end
         end
         ST_FAST: begin
            if (!i_charge_hold_in && ms_tick) begin
               fast_ms_d = fast_ms_q + 24'h00_0001;
            end
            if (i_sense.cutoff) begin
               st_d = ST_DONE;
               cause_d = CAUSE_TEMP;
            end else if (!i_charge_hold_in && timer_end) begin
               st_d = ST_DONE;
               cause_d = CAUSE_TIME;
            end else if (!i_charge_hold_in && drop_q && holdoff_ok && i_sense.det_range) begin
               st_d = ST_DONE;
               cause_d = CAUSE_DROP;
            end
         end
         ST_DONE: st_d = ST_DONE;
         default: st_d = ST_START;
      endcase
      if (i_sense.ceil) begin
         st_d = ST_DONE;
         if (st_q == ST_FAST) begin
            cause_d = CAUSE_CEIL;
         end
      end else if (cyc_start) begin
         st_d = ST_START;
      end
      // gate: open during fast unless held, otherwise one pulse per second
      if (st_q == ST_FAST && !i_charge_hold_in) begin
         gate_oe_d = 1'b0;
      end else begin
         gate_oe_d = !(sec24 < mode_pick(mode_q, TRICKLE_MS_LOW, TRICKLE_MS_MID,
                                          TRICKLE_MS_HIGH));
      end
      case (st_q)
         ST_FAST: lamp_oe_d = i_charge_hold_in ? lamp_oe_q : 1'b1;
         ST_PEND: lamp_oe_d = sec24 < HALF_FLASH_MS;
         default: lamp_oe_d = 1'b0;
      endcase
   end
   // sampling and drop detection
   always_comb begin
      hold_ms_d = hold_ms_q;
      if (!i_charge_hold_in) begin
         hold_ms_d = 4'h0;
      end else if (ms_tick && !hist_erase) begin
         hold_ms_d = hold_ms_q + 4'h1;
      end
      since_d = (ms_tick && since_q != FREE_RUN_MS) ? since_q + 24'h00_0001 : since_q;
      synced_d = synced_q;
      if (since_q >= mode_pick(mode_q, SYNC_MS_LOW, SYNC_MS_MID, SYNC_MS_HIGH)) begin
         synced_d = 1'b0;
      end
      trig = 1'b0;
      if (hold_prev_q && !i_charge_hold_in && !hist_erase) begin
         trig = 1'b1;
         synced_d = 1'b1;
      end else if (!synced_q && since_q >= FREE_RUN_MS) begin
         trig = 1'b1;
      end
      if (trig) begin
         since_d = 24'h00_0000;
      end
      busy_d = busy_q;
      mdiv_d = mdiv_q;
      mcnt_d = mcnt_q;
      acc_d = acc_q;
      peak_d = peak_q;
      last_d = last_q;
      hist_d = hist_q;
      drop_d = drop_q;
      if (!busy_q) begin
         if (trig) begin
            busy_d = 1'b1;
            mdiv_d = 11'h000;
            mcnt_d = 6'h00;
            acc_d = 17'h0_0000;
         end
      end else if (32'(mdiv_q) != MEAS_CYC - 1) begin
         mdiv_d = mdiv_q + 11'h001;
      end else begin
         mdiv_d = 11'h000;
         acc_d = sum;
         mcnt_d = mcnt_q + 6'h01;
         if (mcnt_q == ((mode_q == MODE_HIGH) ? AVG_LAST_NDV : AVG_LAST_PEAK)) begin
            busy_d = 1'b0;
            last_d = avg;
            hist_d = 1'b1;
            peak_d = (!hist_q || avg > peak_q) ? avg : peak_q;
            if (hist_q && peak_q > avg && (peak_q - avg) >=
                ((mode_q == MODE_HIGH) ? DROP_LSB_NDV : DROP_LSB_PEAK)) begin
               drop_d = 1'b1;
            end
         end
      end
      // a long hold or a new cycle starts a fresh history
      if (hist_erase || st_q == ST_START) begin
         hist_d = 1'b0;
         drop_d = 1'b0;
         synced_d = 1'b0;
      end
   end
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_q <= ST_START;
         mode_q <= MODE_LOW;
         cause_q <= 4'h0;
         ms_div_q <= 16'h0000;
         sec_ms_q <= 10'h000;
         fast_ms_q <= 24'h00_0000;
         hold_ms_q <= 4'h0;
         hold_prev_q <= 1'b0;
         ceil_prev_q <= 1'b0;
         since_q <= 24'h00_0000;
         synced_q <= 1'b0;
         busy_q <= 1'b0;
         mdiv_q <= 11'h000;
         mcnt_q <= 6'h00;
         acc_q <= 17'h0_0000;
         peak_q <= 12'h000;
         last_q <= 12'h000;
         hist_q <= 1'b0;
         drop_q <= 1'b0;
         gate_oe_q <= 1'b1;
         lamp_oe_q <= 1'b0;
      end else begin
         st_q <= st_d;
         mode_q <= mode_d;
         cause_q <= cause_d;
         ms_div_q <= ms_div_d;
         sec_ms_q <= sec_ms_d;
         fast_ms_q <= fast_ms_d;
         hold_ms_q <= hold_ms_d;
         hold_prev_q <= i_charge_hold_in;
         ceil_prev_q <= i_sense.ceil;
         since_q <= since_d;
         synced_q <= synced_d;
         busy_q <= busy_d;
         mdiv_q <= mdiv_d;
         mcnt_q <= mcnt_d;
         acc_q <= acc_d;
         peak_q <= peak_d;
         last_q <= last_d;
         hist_q <= hist_d;
         drop_q <= drop_d;
         gate_oe_q <= gate_oe_d;
         lamp_oe_q <= lamp_oe_d;
      end
   end
   assign o_avs_readdata = rdata_q;
   assign o_avs_waitrequest = wait_q;
   // open-drain pins only ever pull low
   assign o_current_gate_out = 1'b0;
   assign o_status_lamp_out = 1'b0;
   assign o_current_gate_out_oe = gate_oe_q;
   assign o_status_lamp_out_oe = lamp_oe_q;
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_b);
   a_ceiling_done: assert property (i_sense.ceil |=> st_q == ST_DONE)
      else $error("ceiling did not force complete state");
   a_cycle_restart: assert property ((ceil_prev_q && !i_sense.ceil) |=> st_q == ST_START)
      else $error("ceiling fall did not restart cycle");
   a_start_fast: assert property ((st_q == ST_START && fast_ok) |=> st_q == ST_FAST)
      else $error("start within limits did not enter fast");
   a_fast_gate_open: assert property ((st_q == ST_FAST && !i_charge_hold_in)
      |=> !o_current_gate_out_oe)
      else $error("gate driven during fast charge");
   a_fast_lamp_low: assert property ((st_q == ST_FAST && !i_charge_hold_in)
      |=> o_status_lamp_out_oe)
      else $error("lamp not driven during fast charge");
   a_done_lamp_off: assert property (st_q == ST_DONE |=> !o_status_lamp_out_oe)
      else $error("lamp driven in complete state");
   a_hold_freeze: assert property ((st_q == ST_FAST && i_charge_hold_in)
      |=> $stable(fast_ms_q))
      else $error("safety timer advanced during hold");
   a_hist_erase: assert property (hist_erase |=> !hist_q && !drop_q)
      else $error("history kept after long hold");
   a_holdoff_keep: assert property ((st_q == ST_FAST && !holdoff_ok && !i_sense.cutoff
      && !timer_end && !i_sense.ceil && !cyc_start) |=> st_q == ST_FAST)
      else $error("fast charge ended inside hold-off");
   a_timer_end: assert property ((st_q == ST_FAST && timer_end && !i_charge_hold_in
      && !cyc_start) |=> st_q == ST_DONE)
      else $error("safety timer expiry ignored");
   a_sync_sample: assert property ((hold_prev_q && !i_charge_hold_in && !hist_erase
      && !busy_q) |=> busy_q)
      else $error("sync falling edge started no sample");
   c_fast: cover property (st_q == ST_PEND ##1 st_q == ST_FAST);
   c_drop_end: cover property (st_q == ST_FAST && cause_d == CAUSE_DROP ##1 st_q == ST_DONE);
   c_flash: cover property (st_q == ST_PEND && lamp_oe_q ##1 !lamp_oe_q);
   c_erase: cover property (hist_q ##1 !hist_q);
endmodule
`default_nettype wire

/* File: bfc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bfc_host_model #(
   parameter int unsigned P_MS_CYC = 4
) (
   input wire logic i_clk_sys,
   input wire logic i_gate_out,
   input wire logic i_gate_out_oe,
   output logic o_charge_hold_in,
   output logic o_gate_pin
);
   // supply switch input has a pull-up: released gate lets current flow
   assign o_gate_pin = i_gate_out_oe ? i_gate_out : 1'b1;
   initial o_charge_hold_in = 1'b0;

   // long holds are used both before and after the sync pulse, and each erases the history
   task automatic hold(input logic v);
      @(posedge i_clk_sys);
      o_charge_hold_in <= v;
   endtask

   // width in whole ms, kept between 100 ns and 3.5 ms by the caller
   task automatic pulse(input int unsigned ms);
      @(posedge i_clk_sys);
      o_charge_hold_in <= 1'b1;
      repeat (ms * P_MS_CYC) @(posedge i_clk_sys);
      o_charge_hold_in <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import bfc_pkg::*;
   localparam int unsigned MSC = 4;
   localparam int unsigned SEC = 1000 * MSC;
   localparam int unsigned LIMIT = 90_000;
   logic i_clk_sys = 1'b0;
   logic i_rst_b = 1'b0;
   bfc_sense_t sense = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
   logic [11:0] meas = 12'h000;
   logic [1:0] mode = 2'b00;
   logic [3:0] addr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdata;
   logic wreq;
   logic gate_out, gate_oe, lamp_out, lamp_oe, hold, gate_pin, lamp_pin;
   int bad_count = 0;
   int checks_done = 0;
   int cyc = 0;
   int w_ms[3] = '{37, 73, 18};

   always #20 i_clk_sys = ~i_clk_sys;
   assign lamp_pin = lamp_oe ? lamp_out : 1'b1;

   bfc_sequencer #(.P_MS_CYC(MSC)) dut (
      .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_sense(sense), .i_cell_meas(meas),
      .i_timer_mode_select(mode), .i_charge_hold_in(hold), .i_avs_address(addr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wreq), .o_current_gate_out(gate_out),
      .o_current_gate_out_oe(gate_oe), .o_status_lamp_out(lamp_out),
      .o_status_lamp_out_oe(lamp_oe)
   );

   bfc_host_model #(.P_MS_CYC(MSC)) u_host (
      .i_clk_sys(i_clk_sys), .i_gate_out(gate_out), .i_gate_out_oe(gate_oe),
      .o_charge_hold_in(hold), .o_gate_pin(gate_pin)
   );

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         bad_count++;
         stop_test();
      end
   end

   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, e, g);
      end
   endtask

   // request held until waitrequest is sampled low; idle edge before the next one
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] v);
      addr <= a;
      wdat <= d;
      rd <= ~w;
      wr <= w;
      @(posedge i_clk_sys);
      while (wreq !== 1'b0) @(posedge i_clk_sys);
      v = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge i_clk_sys);
   endtask

   task automatic poll(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                       output logic [31:0] v);
      int n;
      n = 0;
      bus(1'b0, a, 32'h0000_0000, v);
      while ((v & m) !== e && n < 9000) begin
         bus(1'b0, a, 32'h0000_0000, v);
         n++;
      end
      v = v & m;
   endtask

   // one full second: exact for any phase since both outputs repeat every second
   task automatic sec_count(output int g, output int l);
      g = 0;
      l = 0;
      repeat (SEC) begin
         @(posedge i_clk_sys);
         g += int'(gate_pin === 1'b1);
         l += int'(lamp_pin === 1'b0);
      end
   endtask

   function automatic logic [1:0] enc(input int m);
      return (m == 2) ? 2'b10 : (m == 1) ? 2'b01 : 2'b00;
   endfunction

   function automatic logic [31:0] st(input bfc_sense_t s, input int m);
      int k;
      k = s.ceil ? 3 : (s.floor_ok && s.hot_ok) ? 2 : 1;
      return 32'(m * 4 + k);
   endfunction

   initial begin
      logic [31:0] v;
      int m, g, l;
      void'($urandom(2651));
      m = $urandom_range(0, 2);
      @(posedge i_clk_sys);
      meas <= 12'($urandom_range(2000, 3800));
      mode <= enc(m);
      @(posedge i_clk_sys);
      chk("reset gate", 32'h1, 32'(gate_oe));
      chk("reset lamp", 32'h0, 32'(lamp_oe));
      i_rst_b <= 1'b1;
      poll(REG_STATUS, 32'hF, st(sense, m), v);
      chk("start state", st(sense, m), v);
      sec_count(g, l);
      chk("fast gate", 32'(SEC), 32'(g));
      chk("fast lamp", 32'(SEC), 32'(l));
      sense.ceil <= 1'b1;
      poll(REG_STATUS, 32'hF3, 32'h23, v);
      chk("ceiling stop", 32'h23, v);
      sense.ceil <= 1'b0;
      poll(REG_STATUS, 32'h3, 32'h2, v);
      chk("ceiling fall", 32'h2, v);
      bus(1'b0, REG_CTRL, 32'h0000_0000, v);
      chk("ctrl read", 32'h0, v);
      bus(1'b0, 4'hC, 32'h0000_0000, v);
      chk("unmapped read", 32'h0, v);
      bus(1'b1, REG_STATUS, 32'h0000_0000, v);
      poll(REG_STATUS, 32'h3, 32'h2, v);
      chk("status write", 32'h2, v);
      for (int k = 0; k < 3; k++) begin
         mode <= enc(k);
         sense.hot_ok <= 1'b0;
         bus(1'b1, REG_CTRL, 32'h0000_0001, v);
         poll(REG_STATUS, 32'hF, 32'(k * 4 + 1), v);
         chk("pending state", 32'(k * 4 + 1), v);
         mode <= enc((k + 1) % 3);
         sec_count(g, l);
         chk("trickle width", 32'(w_ms[k] * MSC), 32'(g));
         chk("pending flash", 32'(500 * MSC), 32'(l));
         bus(1'b0, REG_STATUS, 32'h0000_0000, v);
         chk("latched mode", 32'(k * 4 + 1), v & 32'hF);
      end
      sense.hot_ok <= 1'b1;
      poll(REG_STATUS, 32'h3, 32'h2, v);
      chk("pending to fast", 32'h2, v);
      u_host.hold(1'b1);
      poll(REG_STATUS, 32'h103, 32'h102, v);
      chk("held state", 32'h102, v);
      sec_count(g, l);
      chk("held trickle", 32'(w_ms[2] * MSC), 32'(g));
      chk("held lamp", 32'(SEC), 32'(l));
      bus(1'b0, REG_STATUS, 32'h0000_0000, v);
      chk("history erased", 32'h0, v & 32'h400);
      u_host.hold(1'b0);
      poll(REG_STATUS, 32'h103, 32'h002, v);
      chk("resumed", 32'h002, v);
      sec_count(g, l);
      chk("resumed gate", 32'(SEC), 32'(g));
      u_host.pulse(1);
      poll(REG_SAMPLE, 32'hFFF, 32'(meas), v);
      chk("synced sample", 32'(meas), v);
      bus(1'b0, REG_STATUS, 32'h0000_0000, v);
      chk("synced flag", 32'h600, v & 32'h600);
      // a hold well past the erase time must drop the history just built
      u_host.hold(1'b1);
      repeat (20 * MSC) @(posedge i_clk_sys);
      bus(1'b0, REG_STATUS, 32'h0000_0000, v);
      chk("history after long hold", 32'h0, v & 32'h400);
      u_host.hold(1'b0);
      sense.cutoff <= 1'b1;
      poll(REG_STATUS, 32'hF3, 32'h43, v);
      chk("temp stop", 32'h43, v);
      sec_count(g, l);
      chk("done lamp", 32'h0, 32'(l));
      chk("done trickle", 32'(w_ms[2] * MSC), 32'(g));
      stop_test();
   end
endmodule
`default_nettype wire
